// ---- hw/epa_ctrl.sv ----
// Purpose: eeprom page access control with cycle down-counter, ahb-lite slave
// Assumes: single word transfers, zero wait states, okay response only
// Notes:   array is modelled as a register array; erased state reads 00
module epa_ctrl
  import epa_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // timer interrupt request and derivative enable
  input  wire logic        derivIrqEn,
  output logic             timerIrq
);
  initial begin
    if (TICK_DIV < 1 || TICK_DIV > 65535) $error("TICK_DIV out of range");
  end

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic        apWrite_r;
  logic        apRead_r;
  logic [7:0]  apIdx_r;
  logic        accept;
  assign accept = hsel && hready && htrans[1] && (hsize == 3'b010);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      apWrite_r <= 1'b0;
      apRead_r  <= 1'b0;
      apIdx_r   <= 8'h00;
    end else begin
      apWrite_r <= accept && hwrite;
      apRead_r  <= accept && !hwrite;
      apIdx_r   <= haddr[9:2];
    end
  end

  // ****************************************
  // registers and state
  // ****************************************
  logic [7:0]  ptr_r;
  logic        startBit_r;
  logic        irqEn_r;
  logic        flag_r;
  logic        busy_r;
  logic [2:0]  mode_r;
  logic [7:0]  reload_r;
  logic [7:0]  count_r;
  logic        timerRun_r;
  logic [15:0] div_r;
  logic [7:0]  latch_r [4];
  logic [3:0]  sel_r;
  logic [7:0]  mem_r [256];
  epa_state_t  state_r;
  logic        tick;
  logic        underflow;
  logic        cycleEnd;
  logic        wrData;
  logic        wrCtrl;
  logic        rdData;
  logic [5:0]  page;
  logic [7:0]  ptr_nxt;
  logic        startWrite;
  logic        startErase;
  logic        startTimer;
  logic        wrReload;
  logic        wrPtr;
  logic [31:0] phaseCnt_r;

  assign wrData    = apWrite_r && (apIdx_r == ADDR_DATA_IDX);
  assign wrCtrl    = apWrite_r && (apIdx_r == ADDR_CTRL_IDX);
  assign rdData    = apRead_r && (apIdx_r == ADDR_DATA_IDX);
  assign page      = ptr_r[7:2];
  assign tick      = timerRun_r && (div_r == 16'(TICK_DIV - 1));
  assign underflow = tick && (count_r == 8'h00);
  assign cycleEnd  = underflow && (state_r == ST_WRITE || (state_r == ST_ERASE && mode_r == MODE_ERASE));

  // ****************************************
  // address pointer
  // ****************************************
  always_comb begin
    ptr_nxt = ptr_r;
    if (wrPtr) begin
      ptr_nxt = hwdata[7:0];
    end else if (cycleEnd && mode_r != MODE_ERASE) begin
      ptr_nxt = ptr_r + 8'h01;
    end else if (rdData && !busy_r) begin
      ptr_nxt = ptr_r + 8'h01;
    end else if (wrData && mode_r == MODE_INCR && !busy_r && ptr_r[1:0] != 2'b11) begin
      ptr_nxt = {ptr_r[7:2], ptr_r[1:0] + 2'b01};
    end
  end

  // a read in the next address phase sees the moved pointer, so back-to-back reads stay in step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= PTR_RESET;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // ****************************************
  // mode decode of control writes
  // ****************************************
  assign wrPtr      = apWrite_r && (apIdx_r == ADDR_PTR_IDX);
  assign wrReload   = apWrite_r && (apIdx_r == ADDR_RELOAD_IDX);
  assign startTimer = wrCtrl && !busy_r && (hwdata[CTRL_BUSY_BIT] || hwdata[CTRL_START_BIT]);

  always_comb begin
    startWrite = 1'b0;
    startErase = 1'b0;
    if (wrCtrl && !busy_r && hwdata[CTRL_BUSY_BIT]) begin
      case (hwdata[3:1])
        MODE_INCR, 3'b011: begin
          startWrite = 1'b1;
        end
        MODE_ERWR, MODE_ERASE: begin
          startErase = 1'b1;
        end
        default: begin
          // forbidden codes leave busy set with no page cycle behind it
          startErase = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // latches and byte-select flags
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 4'h0;
      for (int i = 0; i < 4; i++) latch_r[i] <= 8'h00;
    end else if (cycleEnd) begin
      sel_r <= 4'h0;
      for (int i = 0; i < 4; i++) latch_r[i] <= 8'h00;
    end else if (wrData && !busy_r) begin
      latch_r[ptr_r[1:0]] <= latch_r[ptr_r[1:0]] | hwdata[7:0];
      sel_r[ptr_r[1:0]]   <= 1'b1;
    end
  end

  // ****************************************
  // array update on phase ends
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (underflow && state_r != ST_IDLE) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_r[b]) begin
          if (state_r == ST_ERASE) mem_r[{page, 2'(b)}] <= ERASED_BYTE;
          else mem_r[{page, 2'(b)}] <= mem_r[{page, 2'(b)}] | latch_r[b];
        end
      end
    end
  end

  // ****************************************
  // reload register and control bits
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_r <= RELOAD_RESET;
    end else if (wrReload) begin
      reload_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {startBit_r, irqEn_r, busy_r, mode_r} <= {CTRL_RESET[7:6], CTRL_RESET[4:1]};
    end else if (cycleEnd) begin
      startBit_r <= 1'b0;
      busy_r     <= 1'b0;
      mode_r     <= MODE_READ;
    end else if (wrCtrl && !busy_r) begin
      startBit_r <= hwdata[CTRL_START_BIT];
      irqEn_r    <= hwdata[CTRL_IRQEN_BIT];
      busy_r     <= hwdata[CTRL_BUSY_BIT];
      mode_r     <= hwdata[3:1];
    end
  end

  // an underflow beats a software clear landing in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= CTRL_RESET[CTRL_FLAG_BIT];
    end else if (underflow) begin
      flag_r <= 1'b1;
    end else if (wrCtrl) begin
      flag_r <= hwdata[CTRL_FLAG_BIT];
    end
  end

  // ****************************************
  // cycle sequencer
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (startWrite) begin
            state_r <= ST_WRITE;
          end else if (startErase) begin
            state_r <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          if (underflow && mode_r == MODE_ERWR) begin
            state_r <= ST_WRITE;
          end else if (cycleEnd) begin
            state_r <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (cycleEnd) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // cycle down-counter and prescaler
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerRun_r <= 1'b0;
    end else if (startTimer) begin
      timerRun_r <= 1'b1;
    end else if (wrCtrl && !busy_r) begin
      timerRun_r <= 1'b0;
    end else if (cycleEnd) begin
      timerRun_r <= 1'b0;
    end
  end

  // prescaler holds on a stop or a cycle end, so a held count reads back unchanged
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
    end else if (startTimer) begin
      div_r <= 16'h0000;
    end else if ((wrCtrl && !busy_r) || cycleEnd) begin
      div_r <= div_r;
    end else if (tick) begin
      div_r <= 16'h0000;
    end else if (timerRun_r) begin
      div_r <= div_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 8'h00;
    end else if (startTimer) begin
      count_r <= reload_r;
    end else if ((wrCtrl && !busy_r) || cycleEnd) begin
      count_r <= count_r;
    end else if (tick) begin
      count_r <= underflow ? reload_r : count_r - 8'h01;
    end
  end

  // ****************************************
  // page cycle length, for the timing check
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseCnt_r <= 32'h0000_0000;
    end else if (startWrite || startErase) begin
      phaseCnt_r <= 32'h0000_0001;
    end else if (busy_r) begin
      phaseCnt_r <= phaseCnt_r + 32'h0000_0001;
    end
  end

  // ****************************************
  // read data, response and interrupt
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      timerIrq  <= 1'b0;
    end else begin
      timerIrq <= flag_r && irqEn_r && derivIrqEn;
      hrdata   <= 32'h0000_0000;
      if (accept && !hwrite) begin
        case (haddr[9:2])
          ADDR_PTR_IDX:    hrdata <= {24'h0, ptr_nxt};
          ADDR_DATA_IDX:   hrdata <= {24'h0, mem_r[ptr_nxt]};
          ADDR_CTRL_IDX:   hrdata <= {24'h0, startBit_r, irqEn_r, flag_r, busy_r, mode_r, 1'b0};
          ADDR_RELOAD_IDX: hrdata <= {24'h0, reload_r};
          ADDR_TIMER_IDX:  hrdata <= {24'h0, count_r};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  addr_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdData && !busy_r && !(apWrite_r && apIdx_r == ADDR_PTR_IDX) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not step after read");
  erase_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cycleEnd && mode_r == MODE_ERASE && !apWrite_r |=> ptr_r == $past(ptr_r))
    else $error("pointer moved after erase");
  incr_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrData && mode_r == MODE_INCR && !busy_r && ptr_r[1:0] == 2'b11 |=> ptr_r[1:0] == 2'b11)
    else $error("subcounter passed latch 3");
  flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrData && !busy_r && !cycleEnd |=> sel_r[$past(ptr_r[1:0])])
    else $error("byte flag not set by latch write");
  latch_or_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cycleEnd |=> (latch_r[0] & $past(latch_r[0])) == $past(latch_r[0]))
    else $error("latch bit cleared");
  end_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cycleEnd |=> sel_r == 4'h0 && !busy_r && mode_r == MODE_READ && flag_r)
    else $error("cycle end did not clear state");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    timerIrq |-> $past(flag_r && irqEn_r && derivIrqEn))
    else $error("interrupt without enables");
  erwr_reload_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    underflow && state_r == ST_ERASE && mode_r == MODE_ERWR |=> state_r == ST_WRITE && count_r == $past(reload_r))
    else $error("erase/write second phase missing");
  write_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    startWrite |=> state_r == ST_WRITE && busy_r && timerRun_r)
    else $error("write page did not start");
  erase_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    startErase |=> state_r == ST_ERASE && busy_r && timerRun_r && count_r == $past(reload_r))
    else $error("erase cycle did not start");
  incr_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrData && mode_r == MODE_INCR && !busy_r && ptr_r[1:0] != 2'b11 |=> ptr_r == {$past(ptr_r[7:2]), $past(ptr_r[1:0]) + 2'b01})
    else $error("subcounter did not step");
  addr_fixed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrData && mode_r != MODE_INCR && !busy_r |=> ptr_r == $past(ptr_r))
    else $error("pointer moved on latch write");
  latch_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrData && !busy_r && ptr_r[1:0] == 2'b00 |=> latch_r[0] == ($past(latch_r[0]) | $past(hwdata[7:0])))
    else $error("latch not loaded by or");
  latch_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cycleEnd |=> latch_r[0] == 8'h00 && latch_r[1] == 8'h00 && latch_r[2] == 8'h00 && latch_r[3] == 8'h00)
    else $error("latches not cleared at cycle end");
  erase_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    underflow && state_r == ST_ERASE && sel_r[0] |=> mem_r[{$past(page), 2'b00}] == ERASED_BYTE)
    else $error("flagged byte not erased");
  keep_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    underflow && state_r != ST_IDLE && !sel_r[1] |=> mem_r[{$past(page), 2'b01}] == $past(mem_r[{page, 2'b01}]))
    else $error("unflagged byte changed");
  write_or_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    underflow && state_r == ST_WRITE && sel_r[2] |=> mem_r[{$past(page), 2'b10}] == ($past(mem_r[{page, 2'b10}]) | $past(latch_r[2])))
    else $error("flagged byte not ored with latch");
  cycle_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cycleEnd |-> int'(phaseCnt_r) == (int'(reload_r) + 1) * TICK_DIV * ((mode_r == MODE_ERWR) ? 2 : 1))
    else $error("page cycle length wrong");
  erase_cv: cover property (@(posedge core_clk) disable iff (!rst_n) cycleEnd && mode_r == MODE_ERASE);
  incr_cv:  cover property (@(posedge core_clk) disable iff (!rst_n) wrData && mode_r == MODE_INCR);
  erwr_cv:  cover property (@(posedge core_clk) disable iff (!rst_n) cycleEnd && mode_r == MODE_ERWR);
  write_cv: cover property (@(posedge core_clk) disable iff (!rst_n) cycleEnd && mode_r[2:1] == 2'b01);
  read_cv:  cover property (@(posedge core_clk) disable iff (!rst_n) rdData);
endmodule : epa_ctrl

// ---- hw/epa_pkg.sv ----
// Purpose: constants for the eeprom page access control block
// Assumes: ahb-lite slave, 32-bit data, one register per aligned word
// Notes:   register indices are byte addresses divided by four
package epa_pkg;
  localparam logic [7:0] ADDR_PTR_IDX   = 8'h01;
  localparam logic [7:0] ADDR_DATA_IDX  = 8'h03;
  localparam logic [7:0] ADDR_CTRL_IDX  = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_IDX = 8'h05;
  localparam logic [7:0] ADDR_TIMER_IDX = 8'h06;
  localparam int         CTRL_START_BIT = 7;
  localparam int         CTRL_IRQEN_BIT = 6;
  localparam int         CTRL_FLAG_BIT  = 5;
  localparam int         CTRL_BUSY_BIT  = 4;
  localparam logic [2:0] MODE_READ      = 3'b000;
  localparam logic [2:0] MODE_INCR      = 3'b010;
  localparam logic [2:0] MODE_ERWR      = 3'b110;
  localparam logic [2:0] MODE_ERASE     = 3'b111;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] RELOAD_RESET   = 8'h00;
  localparam logic [7:0] ERASED_BYTE    = 8'h00;
  localparam int         CLK_MHZ        = 250;
  localparam int         TICK_NS        = 480;
  localparam int         TICK_CYCLES    = (TICK_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b100
  } epa_state_t;
endpackage : epa_pkg

// ---- sim/epa_bus_master.sv ----
// Purpose: ahb-lite master standing in for the core's register accesses
// Assumes: single word transfers, slave hreadyout fed back as hready
// Notes:   waits on hreadyout with no fixed cycle count
module epa_bus_master (
  // clock
  input  wire logic        core_clk,
  // ahb-lite master side
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0;
  end
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h000000, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : epa_bus_master

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the eeprom page access block
// Assumes: TICK_DIV of 1 keeps cycles short
// Notes:   rows are {kind, byte address, data}; kind 0 write, 1 read, 2 wait idle
module tb_top
  import epa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        derivIrqEn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, timerIrq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fails = 0;
  int          testsRun = 0;
  logic [19:0] rows [] = '{
    20'h01403, 20'h01004, 20'h004fc, 20'h00c00, 20'h00c00, 20'h00c00, 20'h00c00, 20'h104ff,
    20'h0101e, 20'h20000, 20'h104ff, 20'h11020,
    20'h01004, 20'h00400, 20'h00cff, 20'h00cff, 20'h00cff, 20'h00cff, 20'h0101e, 20'h20000, 20'h01000,
    20'h00400, 20'h00c30, 20'h00c0c, 20'h10400, 20'h00401, 20'h00ca5, 20'h00403, 20'h00c81,
    20'h0101c, 20'h20000, 20'h10404,
    20'h00400, 20'h10c3c, 20'h10ca5, 20'h10c00, 20'h10c81, 20'h10404,
    20'h01000, 20'h00402, 20'h00c0f, 20'h00400, 20'h00c42, 20'h01014, 20'h20000,
    20'h00400, 20'h10c7e, 20'h10ca5, 20'h10c0f,
    20'h01000, 20'h00403, 20'h00c00, 20'h0101e, 20'h20000,
    20'h00400, 20'h10c7e, 20'h10ca5, 20'h10c0f, 20'h10c00,
    20'h004ff, 20'h10c00, 20'h10400, 20'h02055, 20'h12000};
  always #2 core_clk = ~core_clk;
  epa_ctrl #(.TICK_DIV(1)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .derivIrqEn(derivIrqEn), .timerIrq(timerIrq));
  epa_bus_master m (
    .core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata));
  // ****************
  // tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // polling bounded so a stuck busy bit ends as a mismatch, not a hang
  task automatic wait_idle();
    logic [31:0] v;
    for (int n = 0; n < 100; n++) begin
      m.xfer(1'b0, 8'h10, 8'h00, v);
      if (v[CTRL_BUSY_BIT] === 1'b0) break;
    end
    check("busy clear", {31'h0, v[CTRL_BUSY_BIT]}, 32'h0);
  endtask : wait_idle
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][19:16] == 4'h0) m.xfer(1'b1, rows[i][15:8], rows[i][7:0], rd);
      else if (rows[i][19:16] == 4'h2) wait_idle();
      else begin
        m.xfer(1'b0, rows[i][15:8], 8'h00, rd);
        check($sformatf("row %0d", i), rd, {24'h000000, rows[i][7:0]});
      end
    end
    check("resp", {31'h0, hresp}, 32'h0);
    check("ready", {31'h0, hreadyout}, 32'h1);
    // long cycle with interrupt enabled on both sides
    m.xfer(1'b1, 8'h14, 8'h28, rd);
    derivIrqEn <= 1'b1;
    m.xfer(1'b1, 8'h10, 8'h5e, rd);
    m.xfer(1'b0, 8'h10, 8'h00, rd);
    check("busy set", {31'h0, rd[CTRL_BUSY_BIT]}, 32'h1);
    wait_idle();
    repeat (2) @(posedge core_clk);
    check("irq on", {31'h0, timerIrq}, 32'h1);
    derivIrqEn <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("irq off", {31'h0, timerIrq}, 32'h0);
    m.xfer(1'b0, 8'h18, 8'h00, rd);
    check("counter held", rd, 32'h0);
    // second reset in mid-run
    m.xfer(1'b1, 8'h04, 8'h5a, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    m.xfer(1'b0, 8'h04, 8'h00, rd);
    check("ptr reset", rd, {24'h000000, PTR_RESET});
    m.xfer(1'b0, 8'h10, 8'h00, rd);
    check("ctrl reset", rd, {24'h000000, CTRL_RESET});
    give_verdict();
  end
endmodule : tb_top
